// ---- common/ssf_regs.svh ----
// register offsets, reset values, sync type codes and word lengths of the sync framer
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

`define SSF_OFS_MARKER     8'h83
`define SSF_OFS_DARK       8'h84
`define SSF_OFS_VALID      8'h85
`define SSF_OFS_CRC        8'h86
`define SSF_OFS_ALIGN      8'h87

`define SSF_RST_MARKER     10'h02a
`define SSF_RST_DARK       10'h015
`define SSF_RST_VALID      10'h035
`define SSF_RST_CRC        10'h059
`define SSF_RST_ALIGN      10'h3a6

`define SSF_TYPE_FBEGIN    3'h5
`define SSF_TYPE_FFINISH   3'h6
`define SSF_TYPE_RBEGIN    3'h1
`define SSF_TYPE_RFINISH   3'h2

`define SSF_LEN10_LAST     4'h9
`define SSF_LEN8_LAST      4'h7
`define SSF_MASK10         10'h3ff
`define SSF_MASK8          10'h3fc

`endif

// ---- common/ssf_pkg.sv ----
// types shared by the sync channel framer
package ssf_pkg;
  typedef enum logic [2:0] {
    kind_idle,
    kind_row_begin,
    kind_row_end,
    kind_pixel,
    kind_crc
  } ssf_kind_e;
  typedef logic [9:0] ssf_word_t;
endpackage : ssf_pkg

// ---- core/ssf_framer.sv ----
// sync channel framer: word classification, sync codes and msb-first serializer
`include "ssf_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ssf_framer #(
  parameter int NWIN = 32
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              link_clk,
  input  wire logic              adc_mode8,
  input  wire logic              reg_we,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [9:0]        reg_wdata,
  output logic      [9:0]        reg_rdata,
  output logic                   word_tick,
  input  wire ssf_pkg::ssf_kind_e word_kind,
  input  wire logic              black_line,
  input  wire logic [NWIN-1:0]   row_active,
  input  wire logic [NWIN-1:0]   row_first,
  input  wire logic [NWIN-1:0]   row_last,
  output logic                   id_slot,
  output logic                   sync_out
);
  import ssf_pkg::*;

  // pin synchronisers
  logic       lck1_q, lck2_q, lck3_q, lck_f_q;
  logic       md1_q, md2_q, md3_q, md_f_q;
  logic       lclk_rise;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lck1_q  <= 1'b0;
      lck2_q  <= 1'b0;
      lck3_q  <= 1'b0;
      lck_f_q <= 1'b0;
      md1_q   <= 1'b0;
      md2_q   <= 1'b0;
      md3_q   <= 1'b0;
      md_f_q  <= 1'b0;
    end else begin
      lck1_q <= link_clk;
      lck2_q <= lck1_q;
      lck3_q <= lck2_q;
      md1_q  <= adc_mode8;
      md2_q  <= md1_q;
      md3_q  <= md2_q;
      if (lck2_q == lck3_q) begin
        lck_f_q <= lck2_q;
      end
      if (md2_q == md3_q) begin
        md_f_q <= md2_q;
      end
    end
  end

  assign lclk_rise = lck2_q & lck3_q & ~lck_f_q;

  // configuration registers
  ssf_word_t marker_q, dark_q, valid_q, crc_q, align_q;
  ssf_word_t rdata_d;
  ssf_word_t rdata_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      marker_q <= `SSF_RST_MARKER;
      dark_q   <= `SSF_RST_DARK;
      valid_q  <= `SSF_RST_VALID;
      crc_q    <= `SSF_RST_CRC;
      align_q  <= `SSF_RST_ALIGN;
    end else if (reg_we) begin
      if (reg_addr == `SSF_OFS_MARKER) marker_q <= reg_wdata;
      if (reg_addr == `SSF_OFS_DARK)   dark_q   <= reg_wdata;
      if (reg_addr == `SSF_OFS_VALID)  valid_q  <= reg_wdata;
      if (reg_addr == `SSF_OFS_CRC)    crc_q    <= reg_wdata;
      if (reg_addr == `SSF_OFS_ALIGN)  align_q  <= reg_wdata;
    end
  end

  // read mux, unmapped offsets read zero
  assign rdata_d = (reg_addr == `SSF_OFS_MARKER) ? marker_q :
                   (reg_addr == `SSF_OFS_DARK)   ? dark_q   :
                   (reg_addr == `SSF_OFS_VALID)  ? valid_q  :
                   (reg_addr == `SSF_OFS_CRC)    ? crc_q    :
                   (reg_addr == `SSF_OFS_ALIGN)  ? align_q  : 10'h000;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 10'h000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // highest active window
  logic [4:0] hi_idx;
  logic       hi_found;

  always_comb begin
    hi_idx   = 5'h00;
    hi_found = 1'b0;
    for (int i = 0; i < NWIN; i++) begin
      if (row_active[i]) begin
        hi_idx   = i[4:0];
        hi_found = 1'b1;
      end
    end
  end

  // word classification
  logic       id_pend_q;
  logic [4:0] id_q;
  logic       is_begin, is_end, kind_sync;
  logic [2:0] type_code;
  logic       use_first, use_last;
  ssf_word_t  mask_w, sync_w, id_w, class_w, next_word;
  logic [4:0] id_d;

  assign is_begin  = (word_kind == kind_row_begin);
  assign is_end    = (word_kind == kind_row_end);
  // lower windows never get their own line codes
  assign kind_sync = !id_pend_q && (is_begin || is_end) && (black_line || hi_found);
  assign use_first = !black_line && row_first[hi_idx];
  assign use_last  = !black_line && row_last[hi_idx];
  assign type_code = is_begin ? (use_first ? `SSF_TYPE_FBEGIN : `SSF_TYPE_RBEGIN) :
                                (use_last  ? `SSF_TYPE_FFINISH : `SSF_TYPE_RFINISH);
  assign mask_w    = md_f_q ? `SSF_MASK8 : `SSF_MASK10;
  assign sync_w    = {type_code, marker_q[6:0]} & mask_w;
  // black-line id is a don't-care for the receiver, sent as zero
  assign id_d      = black_line ? 5'h00 : hi_idx;
  assign id_w      = md_f_q ? {3'b000, id_q, 2'b00} : {5'b00000, id_q};
  assign class_w   = (word_kind == kind_pixel) ? (black_line ? dark_q : valid_q) :
                     (word_kind == kind_crc)   ? crc_q :
                                                 align_q;
  // pending id overrides the requested kind; data lanes still carry pixels
  assign next_word = id_pend_q ? id_w :
                     kind_sync ? sync_w :
                                 (class_w & mask_w);

  // serializer
  logic [3:0] bit_cnt_q;
  ssf_word_t  shift_q;
  logic       sync_q;
  logic       id_slot_q;

  assign word_tick = lclk_rise && (bit_cnt_q == 4'h0);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 10'h000;
      sync_q    <= 1'b0;
      id_pend_q <= 1'b0;
      id_q      <= 5'h00;
      id_slot_q <= 1'b0;
    end else if (word_tick) begin
      bit_cnt_q <= md_f_q ? `SSF_LEN8_LAST : `SSF_LEN10_LAST;
      sync_q    <= next_word[9];
      shift_q   <= {next_word[8:0], 1'b0};
      id_pend_q <= kind_sync;
      id_slot_q <= id_pend_q;
      if (kind_sync) begin
        id_q <= id_d;
      end
    end else if (lclk_rise) begin
      bit_cnt_q <= bit_cnt_q - 4'h1;
      sync_q    <= shift_q[9];
      shift_q   <= {shift_q[8:0], 1'b0};
    end
  end

  assign sync_out = sync_q;
  assign id_slot  = id_slot_q;

  // word spacing monitor: link rises since the last load
  logic [3:0] rise_cnt_q;
  logic [3:0] len_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rise_cnt_q <= 4'hf;
      len_q      <= 4'h0;
    end else if (word_tick) begin
      rise_cnt_q <= 4'h0;
      len_q      <= md_f_q ? `SSF_LEN8_LAST : `SSF_LEN10_LAST;
    end else if (lclk_rise && (rise_cnt_q != 4'hf)) begin
      rise_cnt_q <= rise_cnt_q + 4'h1;
    end
  end

  // checks
  sequence s_sync_load;
    word_tick && kind_sync;
  endsequence

  sequence s_id_pending;
    id_pend_q && !word_tick;
  endsequence

  sequence s_id_load;
    word_tick && id_pend_q;
  endsequence

  sequence s_bit_step;
    lclk_rise && !word_tick;
  endsequence

  a_word_length: assert property (@(posedge mclk) disable iff (!resetn)
    word_tick |=> (bit_cnt_q == ($past(md_f_q) ? `SSF_LEN8_LAST : `SSF_LEN10_LAST)))
    else $error("word length not loaded at tick");

  a_msb_first: assert property (@(posedge mclk) disable iff (!resetn)
    word_tick |=> (sync_q == $past(next_word[9])) && (shift_q[9] == $past(next_word[8])))
    else $error("serializer not msb first");

  a_shift_step: assert property (@(posedge mclk) disable iff (!resetn)
    s_bit_step |=> (sync_q == $past(shift_q[9])) && (bit_cnt_q == $past(bit_cnt_q) - 4'h1))
    else $error("serializer did not advance one bit");

  a_bit_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !lclk_rise |=> $stable(sync_q))
    else $error("sync bit changed without a link rise");

  a_rise_once: assert property (@(posedge mclk) disable iff (!resetn)
    lclk_rise |=> !lclk_rise)
    else $error("link rise seen twice");

  a_tick_spacing: assert property (@(posedge mclk) disable iff (!resetn)
    (word_tick && (rise_cnt_q != 4'hf)) |-> (rise_cnt_q == len_q))
    else $error("word boundary off the word length");

  a_id_follows: assert property (@(posedge mclk) disable iff (!resetn)
    s_sync_load |=> s_id_pending [*1])
    else $error("window id not pending after sync word");

  a_id_word_out: assert property (@(posedge mclk) disable iff (!resetn)
    (word_tick && id_pend_q && !md_f_q) |-> (next_word == {5'b00000, id_q}))
    else $error("window id word malformed");

  a_id_word8: assert property (@(posedge mclk) disable iff (!resetn)
    (word_tick && id_pend_q && md_f_q) |-> (next_word[9:2] == {3'b000, id_q}))
    else $error("8-bit window id word malformed");

  a_id_slot_set: assert property (@(posedge mclk) disable iff (!resetn)
    s_id_load |=> id_slot_q)
    else $error("id slot flag not raised for id word");

  a_id_slot_clear: assert property (@(posedge mclk) disable iff (!resetn)
    (word_tick && !id_pend_q) |=> !id_slot_q)
    else $error("id slot flag left up");

  a_id_value: assert property (@(posedge mclk) disable iff (!resetn)
    (s_sync_load and !black_line) |=> (id_q == $past(hi_idx)))
    else $error("window id is not the highest active window");

  a_black_id: assert property (@(posedge mclk) disable iff (!resetn)
    (s_sync_load and black_line) |=> (id_q == 5'h00))
    else $error("black line window id not zero");

  a_frame_begin: assert property (@(posedge mclk) disable iff (!resetn)
    (s_sync_load and (is_begin && use_first)) |-> (next_word[9:7] == `SSF_TYPE_FBEGIN))
    else $error("frame begin code missing on first line");

  a_frame_finish: assert property (@(posedge mclk) disable iff (!resetn)
    (s_sync_load and (is_end && use_last)) |-> (next_word[9:7] == `SSF_TYPE_FFINISH))
    else $error("frame finish code missing on last line");

  a_row_begin: assert property (@(posedge mclk) disable iff (!resetn)
    (s_sync_load and (is_begin && !use_first)) |-> (next_word[9:7] == `SSF_TYPE_RBEGIN))
    else $error("row begin code wrong");

  a_row_finish: assert property (@(posedge mclk) disable iff (!resetn)
    (s_sync_load and (is_end && !use_last)) |-> (next_word[9:7] == `SSF_TYPE_RFINISH))
    else $error("row finish code wrong");

  a_black_rows: assert property (@(posedge mclk) disable iff (!resetn)
    (s_sync_load and black_line) |-> (next_word[9:7] == 3'h1 || next_word[9:7] == 3'h2))
    else $error("frame code on black line");

  a_marker_bits: assert property (@(posedge mclk) disable iff (!resetn)
    (s_sync_load and !md_f_q) |-> (next_word[6:0] == marker_q[6:0]))
    else $error("marker bits wrong");

  a_marker_bits8: assert property (@(posedge mclk) disable iff (!resetn)
    (s_sync_load and md_f_q) |-> (next_word[6:2] == marker_q[6:2]))
    else $error("8-bit marker bits wrong");

  a_highest_win: assert property (@(posedge mclk) disable iff (!resetn)
    (s_sync_load and !black_line) |-> ((row_active >> hi_idx) == 1))
    else $error("window chosen is not the highest active");

  a_no_window: assert property (@(posedge mclk) disable iff (!resetn)
    (word_tick && !id_pend_q && (is_begin || is_end) && !black_line && !hi_found)
      |-> (next_word == (align_q & mask_w)))
    else $error("line code sent with no active window");

  a_idle_pattern: assert property (@(posedge mclk) disable iff (!resetn)
    (word_tick && !id_pend_q && word_kind == kind_idle) |-> (next_word == (align_q & mask_w)))
    else $error("idle word is not the alignment pattern");

  a_crc_code: assert property (@(posedge mclk) disable iff (!resetn)
    (word_tick && !id_pend_q && word_kind == kind_crc) |-> (next_word == (crc_q & mask_w)))
    else $error("checksum indicator missing");

  a_pixel_code: assert property (@(posedge mclk) disable iff (!resetn)
    (word_tick && !id_pend_q && word_kind == kind_pixel)
      |-> (next_word == ((black_line ? dark_q : valid_q) & mask_w)))
    else $error("pixel classification code wrong");

  a_low_bits8: assert property (@(posedge mclk) disable iff (!resetn)
    (word_tick && md_f_q) |-> (next_word[1:0] == 2'b00))
    else $error("8-bit word has low bits set");

  a_reg_write: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_we && (reg_addr == `SSF_OFS_MARKER)) |=> (marker_q == $past(reg_wdata)))
    else $error("marker register write lost");

  a_read_lag: assert property (@(posedge mclk) disable iff (!resetn)
    (!reg_we && (reg_addr == `SSF_OFS_ALIGN)) |=> (reg_rdata == align_q))
    else $error("read data not one cycle behind address");

endmodule : ssf_framer

`default_nettype wire

// ---- tb/ssf_rx_model.sv ----
// receiver model: msb-first deserializer that word-aligns on the alignment pattern
`timescale 1ns/1ps
`default_nettype none
module ssf_rx_model (
  input  wire logic       link_clk,
  input  wire logic       sync_in,
  input  wire logic       mode8,
  input  wire logic [9:0] align,
  output logic            locked,
  output logic [9:0]      word,
  output int              nword
);
  logic [9:0] sh = 10'h000;
  logic       m8 = 1'b0;
  logic       armed = 1'b0;
  int         cnt = 0;
  wire logic [9:0] nsh = {sh[8:0], sync_in};
  wire logic [3:0] last = m8 ? 4'h7 : 4'h9;
  wire logic       hit = m8 ? nsh[7:0] == align[9:2] : nsh == align;
  initial begin
    locked = 1'b0;
    word = 10'h000;
    nword = 0;
  end
  // lock needs two hits one word apart, so a pattern prefix cannot lock
  always @(posedge link_clk) begin
    sh <= nsh;
    m8 <= mode8;
    if (m8 != mode8) begin
      locked <= 1'b0;
      armed <= 1'b0;
      cnt <= 0;
    end else if (locked) begin
      cnt <= cnt == last ? 0 : cnt + 1;
      if (cnt == last) begin
        word <= m8 ? {2'h0, nsh[7:0]} : nsh;
        nword <= nword + 1;
      end
    end else if (hit) begin
      locked <= armed && cnt == last;
      armed <= 1'b1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : ssf_rx_model
`default_nettype wire

// ---- tb/ssf_framer_tb.sv ----
// testbench: register port, sync word classes and 10/8-bit framing
`timescale 1ns/1ps
`default_nettype none
module ssf_framer_tb;
  import ssf_pkg::*;
  logic        mclk = 0, resetn = 0, link_clk = 0, mode8 = 0, reg_we = 0, black = 0, qon = 0;
  logic [7:0]  reg_addr = 8'h83;
  logic [9:0]  reg_wdata = 10'h000;
  logic [9:0]  reg_rdata, rx_word;
  logic [31:0] act = 0, fst = 0, lst = 0;
  ssf_kind_e   kind = kind_idle;
  logic        word_tick, id_slot, sync_out, locked;
  logic [9:0]  rv [5] = '{10'h02a, 10'h015, 10'h035, 10'h059, 10'h3a6};
  logic [9:0]  q [$];
  int          n_mismatch = 0, checked = 0, nword;
  always #25 mclk = ~mclk;
  initial begin
    #7;
    forever #200 link_clk = ~link_clk;
  end
  ssf_framer #(.NWIN(32)) uut (.mclk(mclk), .resetn(resetn), .link_clk(link_clk),
    .adc_mode8(mode8), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .word_tick(word_tick), .word_kind(kind), .black_line(black),
    .row_active(act), .row_first(fst), .row_last(lst), .id_slot(id_slot), .sync_out(sync_out));
  ssf_rx_model rx (.link_clk(link_clk), .sync_in(sync_out), .mode8(mode8), .align(rv[4]),
    .locked(locked), .word(rx_word), .nword(nword));
  task automatic report_and_stop;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [9:0] e);
    @(negedge mclk) reg_addr = a;
    @(negedge mclk) chk(reg_rdata, e);
  endtask : rd
  task automatic tick;
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge mclk);
      if (word_tick === 1'b1) break;
    end
    if (i == 200) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : tick
  task automatic push(input logic [9:0] x);
    if (qon && locked) q.push_back(x);
  endtask : push
  task automatic wd(input ssf_kind_e k, input logic b, input logic [31:0] a, f, l);
    logic [2:0] ty;
    logic [9:0] c;
    int w;
    w = 0;
    for (int i = 0; i < 32; i++) if (a[i]) w = i;
    ty = k == kind_row_begin ? (!b && f[w] ? 3'h5 : 3'h1) : (!b && l[w] ? 3'h6 : 3'h2);
    c = k == kind_idle ? rv[4] : k == kind_crc ? rv[3] : k == kind_pixel ? rv[b ? 1 : 2]
      : {ty, rv[0][6:0]};
    @(negedge mclk);
    kind = k;
    black = b;
    act = a;
    fst = f;
    lst = l;
    tick();
    push(mode8 ? c >> 2 : c);
    if (k == kind_row_begin || k == kind_row_end) begin
      @(negedge mclk);
      chk(id_slot, 10'h0);
      tick();
      push(b ? 10'h0 : 10'(w));
      @(negedge mclk);
      chk(id_slot, 10'h1);
    end
  endtask : wd
  task automatic lock;
    for (int i = 0; i < 60 && (i < 4 || locked !== 1'b1); i++) wd(kind_idle, 0, 0, 0, 0);
    if (locked !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    qon = 1;
  endtask : lock
  task automatic drain;
    repeat (200) @(negedge mclk);
    chk(10'(q.size()), 10'h0);
  endtask : drain
  task automatic seq;
    wd(kind_row_begin, 1, 0, 0, 0);
    wd(kind_pixel, 1, 0, 0, 0);
    wd(kind_row_end, 1, 1, 0, 1);
    wd(kind_row_begin, 0, 1, 1, 0);
    wd(kind_pixel, 0, 1, 0, 0);
    wd(kind_crc, 0, 1, 0, 0);
    wd(kind_row_end, 0, 32'h9, 32'h8, 32'h1);
    wd(kind_row_begin, 0, 32'h9, 0, 0);
    wd(kind_row_end, 0, 32'h8000_0000, 0, 32'h8000_0000);
    wd(kind_idle, 0, 0, 0, 0);
    drain();
  endtask : seq
  always @(nword) begin
    #1;
    if (q.size() > 0) chk(rx_word, q.pop_front());
  end
  initial begin
    repeat (8) @(negedge mclk);
    resetn = 1;
    foreach (rv[i]) rd(8'h83 + 8'(i), rv[i]);
    rd(8'h88, 10'h0);
    @(negedge mclk);
    reg_we = 1;
    reg_addr = 8'h83;
    reg_wdata = 10'h355;
    @(negedge mclk);
    reg_we = 0;
    rv[0] = 10'h355;
    rd(8'h83, 10'h355);
    lock();
    seq();
    qon = 0;
    mode8 = 1;
    lock();
    seq();
    report_and_stop();
  end
endmodule : ssf_framer_tb
`default_nettype wire
